/* hw/cbr_bus_release.sv */
// Bus hand-over arbiter and cycle status outputs of the processor core
// Assumes core cycle requests on sys_clk_in; pins resolved by the pad ring
//
// Operation
// - Hold seen: acknowledge at T4 or TI; code acknowledges at TI only, early_q stays low in minimum mode
// - Float bus together with the acknowledge
// - Hold low drops acknowledge; drive when needed
// - Status active T4..T2, passive from T3/ready
// - Status leaving passive in T4 starts cycle
// - Cycle status three-bit encoding table
// - Status floats weak high during grant
// - Two request/grant pins, first has priority
// - Request/grant pins read inactive when open
// - Grant pulse in T4/TI, then grant state
// - Third pulse ends tenure, reclaim next clock
// - Three pulses, then one idle clock
// - Memory-cycle release conditions at T4
// - Idle bus: release next or start cycle
// - Lock prefix asserts lock until next done
// - Interrupt ack cycles auto-lock T2 to T2
// - Lock floats weak high during grant
// - Queue status one clock later, never floats
// - Queue status two-bit encoding table
// - Mode select low: maximum-mode pin functions
// - Mode select high: minimum-mode hold pair
`include "cbr_cfg.svh"
module cbr_bus_release
   import cbr_pkg::*;
(
   input wire logic sys_clk_in,  // Processor clock
   input wire logic rst_n_in,  // Async reset, active low
   input wire logic config_min_max_select_in,  // Mode strap, high = minimum
   input wire logic hold_req_in,  // Minimum-mode hold request
   input wire logic ready_in,  // Transfer ready
   input wire logic req_grant_high_prio_in,  // Pin level, first request/grant
   input wire logic req_grant_low_prio_in,  // Pin level, second request/grant
   input wire logic cyc_req_in,  // Core wants a bus cycle
   input wire logic [2:0] cyc_type_in,  // Cycle status code of that cycle
   input wire logic cyc_odd_low_in,  // Cycle is low byte of odd word
   input wire logic lock_prefix_in,  // Lock-prefixed instruction running
   input wire logic [1:0] queue_op_in,  // Queue operation this clock
   output logic bus_release_ack_out,  // Hold acknowledge
   output logic bus_float_n_out,  // Low while bus and strobes float
   output logic [2:0] cycle_status_out,  // bit2..bit0
   output logic cycle_status_oe_n_out,  // Low while status driven
   output logic req_grant_high_prio_out,  // Always low when driven
   output logic req_grant_high_prio_oe_n_out,  // Low during grant pulse
   output logic req_grant_low_prio_out,
   output logic req_grant_low_prio_oe_n_out,
   output logic bus_lock_n_out,  // Bus lock, active low
   output logic bus_lock_oe_n_out,  // Low while lock driven
   output logic queue_track_hi_out,
   output logic queue_track_lo_out,
   output logic [2:0] bus_phase_out  // Current phase for the core
);
   // ----------------------------------------
   // Input synchronisers (pins and strap)
   // ----------------------------------------
   logic rg0_s1_q, rg0_s2_q;  // Request/grant pin stages
   logic rg1_s1_q, rg1_s2_q;
   logic mode_s1_q, mode_s2_q;  // Strap stages
   logic [1:0] rg_prev_q;  // Previous synced pin levels
   logic [1:0] echo_s1_q, echo_s2_q;  // Own grant pulse, delayed as the pins
   // Two flops on each pin level
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rg0_s1_q <= 1'b1;
         rg0_s2_q <= 1'b1;
         rg1_s1_q <= 1'b1;
         rg1_s2_q <= 1'b1;
         mode_s1_q <= 1'b1;
         mode_s2_q <= 1'b1;
         rg_prev_q <= 2'h3;
         echo_s1_q <= 2'h0;
         echo_s2_q <= 2'h0;
      end else begin
         rg0_s1_q <= req_grant_high_prio_in;
         rg0_s2_q <= rg0_s1_q;
         rg1_s1_q <= req_grant_low_prio_in;
         rg1_s2_q <= rg1_s1_q;
         mode_s1_q <= config_min_max_select_in;
         mode_s2_q <= mode_s1_q;
         rg_prev_q <= {rg1_s2_q, rg0_s2_q};
         // Our grant pulse shows on the pin too; delay it like the pin
         echo_s1_q <= {!req_grant_low_prio_oe_n_out, !req_grant_high_prio_oe_n_out};
         echo_s2_q <= echo_s1_q;
      end
   end
   // ----------------------------------------
   // Decoded pin events
   // ----------------------------------------
   logic max_mode;  // Maximum-mode pin functions
   logic [1:0] rg_fall;  // Falling edge per pin
   assign max_mode = !mode_s2_q;
   // Open pins rest high through pull-up, so only a low edge counts
   // Echo of our own grant pulse is masked, else it would end the tenure
   assign rg_fall = rg_prev_q & ~{rg1_s2_q, rg0_s2_q} & ~echo_s2_q;
   // ----------------------------------------
   // Arbiter and bus phase state
   // ----------------------------------------
   cbr_phase_t phase_q, phase_d;  // Bus cycle phase
   cbr_rg_t rg_q, rg_d;  // Request/grant state
   logic who_q, who_d;  // Owner pin: 0 first, 1 second
   logic early_q, early_d;  // Request came by T2
   logic [2:0] idle_cnt_q, idle_cnt_d;  // Clocks idle since request
   logic ack_q, ack_d;  // Hold acknowledge
   logic [2:0] cyc_q, cyc_d;  // Latched cycle type
   logic odd_q, odd_d;  // Latched odd-low flag
   logic int_ack_cycle_second_q, int_ack_cycle_second_d;  // Next ack cycle is second
   logic int_ack_cycle_lock_q, int_ack_cycle_lock_d;  // Auto lock from ack cycles
   logic released;  // Bus floated this clock
   logic release_ok;  // Release conditions met at this boundary
   // Next arbiter and phase values
   always_comb begin
      phase_d = phase_q;
      rg_d = rg_q;
      who_d = who_q;
      early_d = early_q;
      idle_cnt_d = idle_cnt_q;
      ack_d = ack_q;
      cyc_d = cyc_q;
      odd_d = odd_q;
      int_ack_cycle_second_d = int_ack_cycle_second_q;
      int_ack_cycle_lock_d = int_ack_cycle_lock_q;
      released = ack_q || rg_q == CBR_RG_GNT || rg_q == CBR_RG_HELD;
      // Conditions checked at T4 of a memory cycle or while idle
      release_ok = (early_q || phase_q == CBR_TI) && !odd_q && !lock_prefix_in
         && !(cyc_q == `CBR_ST_INT_ACK_CYCLE && !int_ack_cycle_second_q);
      // Minimum mode hold pair, taken without synchroniser
      if (!max_mode) begin
         if (hold_req_in && !ack_q && (phase_q == CBR_T4 || phase_q == CBR_TI)
            && release_ok) begin
            ack_d = 1'b1;
         end else if (!hold_req_in && ack_q) begin
            ack_d = 1'b0;
         end
      end else begin
         ack_d = 1'b0;
      end
      // Request/grant sequence, first pin wins on ties
      case (rg_q)
         CBR_RG_IDLE: begin
            if (max_mode && rg_fall != 2'h0) begin
               rg_d = CBR_RG_PEND;
               who_d = !rg_fall[0];
               early_d = phase_q == CBR_T1 || phase_q == CBR_T2 || phase_q == CBR_TI;
               idle_cnt_d = 3'h0;
            end
         end
         CBR_RG_PEND: begin
            if ((phase_q == CBR_T4 || phase_q == CBR_TI) && release_ok) begin
               rg_d = CBR_RG_GNT;
            end
            if (phase_q == CBR_TI && idle_cnt_q < `CBR_IDLE_START_CLKS) begin
               idle_cnt_d = 3'(idle_cnt_q + 3'h1);
            end
            if (phase_q == CBR_T4 && !release_ok) begin
               early_d = 1'b1;  // Cleared again by the T4 branch of the phase sequencer
            end
         end
         CBR_RG_GNT: begin
            rg_d = CBR_RG_HELD;
         end
         CBR_RG_HELD: begin
            if (rg_fall[who_q]) begin
               rg_d = CBR_RG_GAP;
            end
         end
         CBR_RG_GAP: begin
            rg_d = CBR_RG_IDLE;
         end
         default: begin
            rg_d = CBR_RG_IDLE;
         end
      endcase
      // Bus cycle phase sequencer
      case (phase_q)
         CBR_TI: begin
            if (cyc_req_in && !released && rg_d != CBR_RG_GNT && !(ack_d && !ack_q)) begin
               phase_d = CBR_T1;
               cyc_d = cyc_type_in;
               odd_d = cyc_odd_low_in;
            end
         end
         CBR_T1: begin
            phase_d = CBR_T2;
            if (cyc_q == `CBR_ST_INT_ACK_CYCLE && int_ack_cycle_second_q) begin
               int_ack_cycle_lock_d = 1'b0;
            end else if (cyc_q == `CBR_ST_INT_ACK_CYCLE) begin
               int_ack_cycle_lock_d = max_mode;
            end
         end
         CBR_T2: begin
            phase_d = CBR_T3;
         end
         CBR_T3, CBR_TW: begin
            phase_d = ready_in ? CBR_T4 : CBR_TW;
         end
         CBR_T4: begin
            if (cyc_q == `CBR_ST_INT_ACK_CYCLE) begin
               int_ack_cycle_second_d = !int_ack_cycle_second_q;
            end
            early_d = 1'b0;
            cyc_d = `CBR_ST_PASSIVE;
            odd_d = 1'b0;
            if (cyc_req_in && rg_d != CBR_RG_GNT && !ack_d) begin
               phase_d = CBR_T1;
               cyc_d = cyc_type_in;
               odd_d = cyc_odd_low_in;
            end else begin
               phase_d = CBR_TI;
            end
         end
         default: begin
            phase_d = CBR_TI;
         end
      endcase
   end
   // Register arbiter and phase state
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_q <= CBR_TI;
         rg_q <= CBR_RG_IDLE;
         who_q <= 1'b0;
         early_q <= 1'b0;
         idle_cnt_q <= 3'h0;
         ack_q <= 1'b0;
         cyc_q <= `CBR_ST_PASSIVE;
         odd_q <= 1'b0;
         int_ack_cycle_second_q <= 1'b0;
         int_ack_cycle_lock_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         rg_q <= rg_d;
         who_q <= who_d;
         early_q <= early_d;
         idle_cnt_q <= idle_cnt_d;
         ack_q <= ack_d;
         cyc_q <= cyc_d;
         odd_q <= odd_d;
         int_ack_cycle_second_q <= int_ack_cycle_second_d;
         int_ack_cycle_lock_q <= int_ack_cycle_lock_d;
      end
   end
   // ----------------------------------------
   // Pin output registers
   // ----------------------------------------
   logic [2:0] st_d;  // Next cycle status
   logic st_oe_n_d, lock_n_d, lock_oe_n_d, float_n_d;
   logic [1:0] qs_d;  // Next queue status
   // Next pin values
   always_comb begin
      float_n_d = !(ack_d || rg_d == CBR_RG_GNT || rg_d == CBR_RG_HELD);
      // Status active from T4 before a cycle through T2
      if (phase_d == CBR_T1 || phase_d == CBR_T2) begin
         st_d = cyc_d;
      end else if (phase_d == CBR_T4 && phase_q != CBR_T4 && cyc_req_in && rg_d == CBR_RG_IDLE) begin
         st_d = cyc_type_in;
      end else begin
         st_d = `CBR_ST_PASSIVE;
      end
      st_oe_n_d = !(max_mode && float_n_d);
      lock_n_d = !(lock_prefix_in || int_ack_cycle_lock_d);
      lock_oe_n_d = !float_n_d;
      qs_d = max_mode ? queue_op_in : `CBR_QS_NOP;
   end
   // Register pins; queue status never floats
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus_release_ack_out <= 1'b0;
         bus_float_n_out <= 1'b1;
         cycle_status_out <= `CBR_ST_PASSIVE;
         cycle_status_oe_n_out <= 1'b1;
         req_grant_high_prio_out <= 1'b0;
         req_grant_high_prio_oe_n_out <= 1'b1;
         req_grant_low_prio_out <= 1'b0;
         req_grant_low_prio_oe_n_out <= 1'b1;
         bus_lock_n_out <= 1'b1;
         bus_lock_oe_n_out <= 1'b1;
         queue_track_hi_out <= 1'b0;
         queue_track_lo_out <= 1'b0;
         bus_phase_out <= 3'h0;
      end else begin
         bus_release_ack_out <= ack_d;
         bus_float_n_out <= float_n_d;
         cycle_status_out <= st_d;
         cycle_status_oe_n_out <= st_oe_n_d;
         req_grant_high_prio_out <= 1'b0;
         req_grant_high_prio_oe_n_out <= !(rg_d == CBR_RG_GNT && !who_d);
         req_grant_low_prio_out <= 1'b0;
         req_grant_low_prio_oe_n_out <= !(rg_d == CBR_RG_GNT && who_d);
         bus_lock_n_out <= lock_n_d;
         bus_lock_oe_n_out <= lock_oe_n_d;
         queue_track_hi_out <= qs_d[1];
         queue_track_lo_out <= qs_d[0];
         bus_phase_out <= phase_d;
      end
   end
endmodule

/* hw/cbr_cfg.svh */
// Constants of the bus release and cycle status block
// Assumes inclusion by the design module only
`ifndef CBR_CFG_SVH
`define CBR_CFG_SVH
// ----------------------------------------
// Cycle status encodings
// ----------------------------------------
`define CBR_ST_INT_ACK_CYCLE 3'h0
`define CBR_ST_IORD 3'h1
`define CBR_ST_IOWR 3'h2
`define CBR_ST_HALT 3'h3
`define CBR_ST_CODE 3'h4
`define CBR_ST_MEMRD 3'h5
`define CBR_ST_MEMWR 3'h6
`define CBR_ST_PASSIVE 3'h7
// ----------------------------------------
// Queue status encodings
// ----------------------------------------
`define CBR_QS_NOP 2'h0
`define CBR_QS_FIRST 2'h1
`define CBR_QS_EMPTY 2'h2
`define CBR_QS_SUBSEQ 2'h3
// ----------------------------------------
// Timing counts (clocks)
// ----------------------------------------
`define CBR_IDLE_START_CLKS 3'h3
`define CBR_GAP_CLKS 2'h1
`endif

/* hw/cbr_pkg.sv */
// Types of the bus release and cycle status block
// Assumes cbr_cfg.svh on the include path
package cbr_pkg;
   // ----------------------------------------
   // Bus cycle phases, Gray along T1..T3 and through TW to T4
   // ----------------------------------------
   typedef enum logic [2:0] {
      CBR_TI = 3'h0,  // Idle
      CBR_T1 = 3'h1,
      CBR_T2 = 3'h3,
      CBR_T3 = 3'h2,
      CBR_TW = 3'h6,  // Wait state
      CBR_T4 = 3'h7
   } cbr_phase_t;
   // ----------------------------------------
   // Request/grant sequence states
   // ----------------------------------------
   typedef enum logic [2:0] {
      CBR_RG_IDLE = 3'h0,  // No request
      CBR_RG_PEND = 3'h1,  // Request seen, waiting release point
      CBR_RG_GNT = 3'h3,  // Grant pulse driven
      CBR_RG_HELD = 3'h2,  // Grant sequence state
      CBR_RG_GAP = 3'h6   // Idle clock after exchange
   } cbr_rg_t;
endpackage

/* tb/cbr_bus_release_checker.sv */
// Port checker of the bus release and cycle status block
// Assumes a bind onto cbr_bus_release from the bench top
module cbr_bus_release_checker
   import cbr_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic config_min_max_select_in,
   input wire logic hold_req_in,
   input wire logic [1:0] queue_op_in,
   input wire logic bus_release_ack_out,
   input wire logic bus_float_n_out,
   input wire logic [2:0] cycle_status_out,
   input wire logic cycle_status_oe_n_out,
   input wire logic req_grant_high_prio_out,
   input wire logic req_grant_high_prio_oe_n_out,
   input wire logic req_grant_low_prio_out,
   input wire logic req_grant_low_prio_oe_n_out,
   input wire logic bus_lock_oe_n_out,
   input wire logic queue_track_hi_out,
   input wire logic queue_track_lo_out,
   input wire logic [2:0] bus_phase_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // Clocking and settled mode
   // ----------------------------------------
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence max_s;  // Strap low long enough to be synced
      !config_min_max_select_in && $past(config_min_max_select_in, 3) == 1'b0 && $past(rst_n_in, 3);
   endsequence
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   ack_float_a: assert property (bus_release_ack_out |-> !bus_float_n_out)
      else $error("acknowledge without floated bus");
   ack_take_a: assert property ($rose(bus_release_ack_out) |->
      $past(hold_req_in) && ($past(bus_phase_out) == CBR_TI || $past(bus_phase_out) == CBR_T4))
      else $error("acknowledge outside idle or T4");
   ack_drop_a: assert property (bus_release_ack_out && !hold_req_in |=> !bus_release_ack_out)
      else $error("acknowledge kept after hold low");
   grant_pulse_a: assert property (!req_grant_high_prio_oe_n_out |->
      !req_grant_high_prio_out && !bus_float_n_out ##1 req_grant_high_prio_oe_n_out)
      else $error("grant pulse not one clock low");
   grant_excl_a: assert property (!(!req_grant_high_prio_oe_n_out && !req_grant_low_prio_oe_n_out))
      else $error("both pins granted");
   stat_float_a: assert property (!req_grant_high_prio_oe_n_out || !req_grant_low_prio_oe_n_out
      |=> cycle_status_oe_n_out) else $error("status driven in grant");
   lock_float_a: assert property (!req_grant_high_prio_oe_n_out || !req_grant_low_prio_oe_n_out
      |=> bus_lock_oe_n_out) else $error("lock driven in grant");
   stat_pass_a: assert property (bus_phase_out == CBR_T3 && !cycle_status_oe_n_out
      |-> cycle_status_out == 3'h7) else $error("status not passive in T3");
   queue_next_a: assert property (max_s |->
      {queue_track_hi_out, queue_track_lo_out} == $past(queue_op_in)) else $error("queue status late");
   max_noack_a: assert property (max_s |-> !bus_release_ack_out)
      else $error("hold acknowledged in maximum mode");
   grant_lo_pulse_a: assert property (!req_grant_low_prio_oe_n_out |->
      !req_grant_low_prio_out && !bus_float_n_out ##1 req_grant_low_prio_oe_n_out)
      else $error("second grant pulse not one clock low");
   cover property ($rose(bus_release_ack_out));
   cover property (!req_grant_high_prio_oe_n_out);
   cover property (bus_phase_out == CBR_TW);
endmodule

/* tb/cbr_bus_release_tb_top.sv */
// Bench top of the bus release and cycle status block
// Assumes the design, package and master model compiled first
module cbr_bus_release_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import cbr_pkg::*;
   logic sys_clk_in = 1'b0, rst_n_in, config_min_max_select_in, hold_req_in, ready_in, cyc_req_in;
   logic cyc_odd_low_in, lock_prefix_in, bus_release_ack_out, bus_float_n_out, cycle_status_oe_n_out;
   logic req_grant_high_prio_out, req_grant_high_prio_oe_n_out, req_grant_low_prio_out;
   logic req_grant_low_prio_oe_n_out, bus_lock_n_out, bus_lock_oe_n_out, queue_track_hi_out, queue_track_lo_out;
   logic [2:0] cyc_type_in, cycle_status_out, bus_phase_out;
   logic [1:0] queue_op_in;
   wire logic req_grant_high_prio_in, req_grant_low_prio_in;
   logic g0, g1;  // Grants seen by the masters
   int fails = 0, checked = 0, n;
   cbr_bus_release cbr_bus_release_i (.*);
   cbr_master_model cbr_master_model_hi_i (.sys_clk_in, .dev_drv_in(req_grant_high_prio_out),
      .dev_oe_n_in(req_grant_high_prio_oe_n_out), .pin_out(req_grant_high_prio_in));
   cbr_master_model cbr_master_model_lo_i (.sys_clk_in, .dev_drv_in(req_grant_low_prio_out),
      .dev_oe_n_in(req_grant_low_prio_oe_n_out), .pin_out(req_grant_low_prio_in));
   initial forever #25 sys_clk_in = ~sys_clk_in;
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task print_verdict();
      $display("checks=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task hang();
      fails++;
      print_verdict();
   endtask
   task do_reset(input logic mode);
      rst_n_in = 1'b0;
      config_min_max_select_in = mode;
      repeat (2) @(negedge sys_clk_in);
      chk(8'({bus_release_ack_out, bus_float_n_out, cycle_status_out, req_grant_high_prio_oe_n_out}), 8'h1f);
      rst_n_in = 1'b1;
      repeat (3) @(negedge sys_clk_in);
   endtask
   task wait_phase(input logic [2:0] ph);
      for (n = 0; n < 12 && bus_phase_out !== ph; n++) @(negedge sys_clk_in);
      if (n == 12) hang();
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_hold();
      do_reset(1'b1);
      hold_req_in = 1'b1;
      for (n = 0; n < 10 && bus_release_ack_out !== 1'b1; n++) @(negedge sys_clk_in);
      chk(8'(bus_release_ack_out), 8'h1);
      chk(8'(bus_float_n_out), 8'h0);
      hold_req_in = 1'b0;
      @(negedge sys_clk_in);
      chk(8'({bus_release_ack_out, bus_float_n_out}), 8'h1);
      $display("hold test done");
   endtask
   task t_status();
      do_reset(1'b0);
      for (int k = 0; k < 8; k++) begin
         cyc_type_in = (k == 7) ? 3'h0 : 3'(k);
         cyc_req_in = 1'b1;
         wait_phase(CBR_T1);
         cyc_req_in = 1'b0;
         chk(8'(cycle_status_out), 8'(cyc_type_in));
         chk(8'(cycle_status_oe_n_out), 8'h0);
         if (k == 1) chk(8'(bus_lock_n_out), 8'h0);
         wait_phase(CBR_T3);
         chk(8'(cycle_status_out), 8'h7);
         ready_in = (k != 5);
         @(negedge sys_clk_in);
         if (k == 5) chk(8'(bus_phase_out), 8'h6);
         ready_in = 1'b1;
      end
      chk(8'(bus_lock_n_out), 8'h1);
      $display("status test done");
   endtask
   task t_queue();
      for (int q = 0; q < 4; q++) begin
         queue_op_in = 2'(q);
         @(negedge sys_clk_in);
         chk(8'({queue_track_hi_out, queue_track_lo_out}), 8'(q));
      end
      queue_op_in = 2'h0;
      $display("queue test done");
   endtask
   task t_grant();
      fork
         cbr_master_model_hi_i.tenure(3, g0);
         cbr_master_model_lo_i.tenure(3, g1);
         begin
            for (n = 0; n < 12 && req_grant_high_prio_oe_n_out && req_grant_low_prio_oe_n_out; n++)
               @(negedge sys_clk_in);
            chk(8'({req_grant_high_prio_oe_n_out, req_grant_low_prio_oe_n_out}), 8'h1);
            @(negedge sys_clk_in);
            chk(8'({bus_float_n_out, cycle_status_oe_n_out, bus_lock_oe_n_out}), 8'h3);
         end
      join
      chk(8'(g0), 8'h1);
      chk(8'(bus_float_n_out), 8'h1);
      cbr_master_model_lo_i.tenure(2, g1);
      chk(8'(g1), 8'h1);
      $display("grant test done");
   endtask
   task t_lock();
      lock_prefix_in = 1'b1;
      for (n = 0; n < 6 && bus_lock_n_out !== 1'b0; n++) @(negedge sys_clk_in);
      chk(8'(bus_lock_n_out), 8'h0);
      lock_prefix_in = 1'b0;
      for (n = 0; n < 6 && bus_lock_n_out !== 1'b1; n++) @(negedge sys_clk_in);
      chk(8'(bus_lock_n_out), 8'h1);
      lock_prefix_in = 1'b1;
      fork
         cbr_master_model_hi_i.tenure(2, g0);
         begin
            repeat (5) @(negedge sys_clk_in);
            chk(8'(bus_float_n_out), 8'h1);
            lock_prefix_in = 1'b0;
         end
      join
      chk(8'(g0), 8'h1);
      $display("lock test done");
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst_n_in = 1'b0;
      config_min_max_select_in = 1'b1;
      {hold_req_in, cyc_req_in, cyc_odd_low_in, lock_prefix_in} = 4'h0;
      ready_in = 1'b1;
      cyc_type_in = 3'h4;
      queue_op_in = 2'h0;
      t_hold();
      t_status();
      t_queue();
      t_grant();
      t_lock();
      print_verdict();
   end
endmodule
bind cbr_bus_release cbr_bus_release_checker cbr_bus_release_checker_i (.*);

/* tb/cbr_master_model.sv */
// Model of one other local bus master on a request/grant pin
// Assumes the device grant pulse arrives on dev_oe_n_in
module cbr_master_model (
   input wire logic sys_clk_in,
   input wire logic dev_drv_in,  // Device pin value
   input wire logic dev_oe_n_in,  // Device drives pin when low
   output logic pin_out  // Resolved pin level
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pull_low = 1'b0;  // Master pulls the pin low
   int gnt = 0;  // Grant pulses seen
   // Pull-up wins when nobody drives
   assign pin_out = !dev_oe_n_in ? dev_drv_in : !pull_low;
   always @(posedge sys_clk_in) begin
      if (dev_oe_n_in === 1'b0) gnt++;
   end
   // One clock low pulse
   task pulse();
      @(negedge sys_clk_in) pull_low = 1'b1;
      @(negedge sys_clk_in) pull_low = 1'b0;
   endtask
   // Request, wait grant, hold, release, idle gap
   task tenure(input int clks, output logic got);
      int n;
      n = gnt;
      pulse();
      for (int i = 0; i < 12 && gnt == n; i++) @(negedge sys_clk_in);
      got = (gnt != n);
      if (got) begin
         repeat (clks) @(negedge sys_clk_in);
         pulse();
      end
      repeat (4) @(negedge sys_clk_in);
   endtask
endmodule
